// ===== pkg/init2_pkg.sv
// constants for the phase 2 identification message builder
package init2_pkg;
	// message shape
	localparam int NIB_COUNT = 32;
	localparam int IDX_W = 5;
	localparam logic [4:0] IDX_LAST = 5'h1f;
	// hard-coded nibble values
	localparam logic [3:0] PROTO_REV_NIB = 4'h4;
	localparam logic [3:0] BLOCKS_HI_NIB = 4'h2;
	localparam logic [3:0] BLOCKS_LO_NIB = 4'h0;
	localparam logic [3:0] SENSOR_TYPE_HI_NIB = 4'h0;
	localparam logic [3:0] SENSOR_TYPE_LO_NIB = 4'h1;
	localparam logic [3:0] RANGE_BASE_NIB = 4'h7;
	localparam logic [3:0] ZERO_NIB = 4'h0;
	// apb byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MAKER_OFS = 8'h04;
	localparam logic [7:0] CFG_ONE_OFS = 8'h08;
	localparam logic [7:0] CFG_TWO_OFS = 8'h0c;
	localparam logic [7:0] CFG_SIX_OFS = 8'h10;
	localparam logic [7:0] CFG_SEVEN_OFS = 8'h14;
	localparam logic [7:0] CFG_EIGHT_OFS = 8'h18;
	localparam logic [7:0] SERIAL_OFS = 8'h1c;
	localparam logic [7:0] STATUS_OFS = 8'h20;
	// control register fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_EXT_BIT = 1;
	localparam int CTRL_REP_LSB = 4;
	localparam int CTRL_AXIS_LSB = 8;
	localparam int CTRL_RANGE_LSB = 10;
	// reset values
	localparam logic [3:0] REP_RESET = 4'h4;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [31:0] SERIAL_RESET = 32'h0000_0000;
	// status register fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_OFS_BIT = 2;
	localparam int ST_SELF_BIT = 3;
	localparam int ST_IDX_LSB = 8;
	localparam int ST_REP_LSB = 16;
	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_DONE = 3'b100
	} seq_state_type;
endpackage

// ===== hw/init2_message_builder.sv
// phase 2 identification message builder, 10-bit mode, with apb registers
// Summary of operation
// - first data nibble is protocol revision 0100.
// - nibbles two and three carry block count 32 as 0010, 0000.
// - nibbles six and seven carry high-g sensor type 0000, 0001.
// - nibble eight is axis setting shifted up two bits.
// - nibble nine is range code 0111 through 1010.
// - nibbles fifteen to eighteen carry binary date, year high first, day low last.
// - nibbles 27 to 31 carry offset then averaged self-test, nibble 29 mixed.
// - offset and self-test nibbles are zero unless extended payload enabled.
// - nibble 32 is config one upper nibble if extended, else zero.
// - measured values inserted only once self-test results are available.
// - results not yet available are sent as zero nibbles.
// - each nibble sends ID then data, repeated k times (once when k is zero) before next.
`timescale 1ns/10ps
module init2_message_builder
	import init2_pkg::*;
#(
	parameter logic [7:0] PRODUCT_REV = 8'h00 // factory revision, value arbitrary
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sync pulse from the line receiver
	input wire logic sync_pulse_in,
	// self-test results
	input wire logic offset_ready,
	input wire logic [9:0] raw_offset,
	input wire logic selftest_ready,
	input wire logic [9:0] averaged_selftest_value,
	// transmission request to the frame encoder
	output logic tx_strobe,
	output logic tx_is_id,
	output logic [3:0] tx_nibble,
	output logic [4:0] tx_index,
	output logic msg_busy,
	output logic msg_done
);

	generate
		if (NIB_COUNT != 32) begin : bad_nib_count
			$error("message length must be 32 nibbles");
		end
	endgenerate

	seq_state_type state_q;
	logic [3:0] rep_k_q;
	logic ext_q;
	logic [1:0] axis_q;
	logic [1:0] range_q;
	logic [7:0] maker_code_field;
	logic [7:0] device_config_one;
	logic [7:0] device_config_two;
	logic [7:0] device_config_six;
	logic [7:0] device_config_seven;
	logic [7:0] device_config_eight;
	logic [31:0] serial_q;
	logic [4:0] idx_q;
	logic [3:0] rep_q;
	logic half_q;
	logic [2:0] sync_q;
	logic sync_evt;
	logic apb_acc;
	logic wr_en;
	logic start_req;
	logic addr_ok;
	logic [31:0] rd_d;
	logic [31:0] status_w;
	logic [6:0] date_year;
	logic [3:0] date_month;
	logic [4:0] date_day;
	logic [3:0] nib_d;
	logic rep_last;

	// access phase seen; answer comes one cycle later so that read data is registered
	assign apb_acc = psel && penable && !pready;
	assign wr_en = psel && penable && pready && pwrite && !pslverr;
	assign start_req = wr_en && (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT];

	// address decode over the mapped word offsets
	always_comb begin
		addr_ok = 1'b1;
		case (paddr)
			CTRL_OFS, MAKER_OFS, CFG_ONE_OFS, CFG_TWO_OFS, CFG_SIX_OFS: addr_ok = 1'b1;
			CFG_SEVEN_OFS, CFG_EIGHT_OFS, SERIAL_OFS, STATUS_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// status word shows the sequencer and result availability
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[ST_BUSY_BIT] = state_q == ST_SEND;
		status_w[ST_DONE_BIT] = state_q == ST_DONE;
		status_w[ST_OFS_BIT] = offset_ready;
		status_w[ST_SELF_BIT] = selftest_ready;
		status_w[ST_IDX_LSB +: 5] = idx_q;
		status_w[ST_REP_LSB +: 4] = rep_q;
	end

	// read mux, unmapped words read zero
	always_comb begin
		rd_d = 32'h0000_0000;
		case (paddr)
			CTRL_OFS: begin
				rd_d[CTRL_EXT_BIT] = ext_q;
				rd_d[CTRL_REP_LSB +: 4] = rep_k_q;
				rd_d[CTRL_AXIS_LSB +: 2] = axis_q;
				rd_d[CTRL_RANGE_LSB +: 2] = range_q;
			end
			MAKER_OFS: rd_d[7:0] = maker_code_field;
			CFG_ONE_OFS: rd_d[7:0] = device_config_one;
			CFG_TWO_OFS: rd_d[7:0] = device_config_two;
			CFG_SIX_OFS: rd_d[7:0] = device_config_six;
			CFG_SEVEN_OFS: rd_d[7:0] = device_config_seven;
			CFG_EIGHT_OFS: rd_d[7:0] = device_config_eight;
			SERIAL_OFS: rd_d = serial_q;
			STATUS_OFS: rd_d = status_w;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// apb answer flops: one wait state on every transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apb_acc;
			pslverr <= apb_acc && !addr_ok;
			if (apb_acc && !pwrite) begin
				prdata <= rd_d;
			end
		end
	end

	// configuration registers; changes during a message show up in later nibbles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_q <= 1'b0;
			rep_k_q <= REP_RESET;
			axis_q <= 2'b00;
			range_q <= 2'b00;
			maker_code_field <= CFG_RESET;
			device_config_one <= CFG_RESET;
			device_config_two <= CFG_RESET;
			device_config_six <= CFG_RESET;
			device_config_seven <= CFG_RESET;
			device_config_eight <= CFG_RESET;
			serial_q <= SERIAL_RESET;
		end else if (wr_en) begin
			case (paddr)
				CTRL_OFS: begin
					ext_q <= pwdata[CTRL_EXT_BIT];
					rep_k_q <= pwdata[CTRL_REP_LSB +: 4];
					axis_q <= pwdata[CTRL_AXIS_LSB +: 2];
					range_q <= pwdata[CTRL_RANGE_LSB +: 2];
				end
				MAKER_OFS: maker_code_field <= pwdata[7:0];
				CFG_ONE_OFS: device_config_one <= pwdata[7:0];
				CFG_TWO_OFS: device_config_two <= pwdata[7:0];
				CFG_SIX_OFS: device_config_six <= pwdata[7:0];
				CFG_SEVEN_OFS: device_config_seven <= pwdata[7:0];
				CFG_EIGHT_OFS: device_config_eight <= pwdata[7:0];
				SERIAL_OFS: serial_q <= pwdata;
				default: ;
			endcase
		end
	end

	// sync pulse from a pin: two-flop synchroniser, edge taken after the second flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 3'b000;
		end else begin
			sync_q <= {sync_q[1:0], sync_pulse_in};
		end
	end
	assign sync_evt = sync_q[1] && !sync_q[2];

	// binary date from config seven and eight
	assign date_year = device_config_seven[6:0];
	assign date_month = {device_config_seven[7], device_config_eight[7:5]};
	assign date_day = device_config_eight[4:0];

	// data nibble for the current index
	always_comb begin
		nib_d = ZERO_NIB;
		case (idx_q)
			5'd0: nib_d = PROTO_REV_NIB;
			5'd1: nib_d = BLOCKS_HI_NIB;
			5'd2: nib_d = BLOCKS_LO_NIB;
			5'd3: nib_d = maker_code_field[7:4];
			5'd4: nib_d = maker_code_field[3:0];
			5'd5: nib_d = SENSOR_TYPE_HI_NIB;
			5'd6: nib_d = SENSOR_TYPE_LO_NIB;
			5'd7: nib_d = {axis_q, 2'b00};
			5'd8: nib_d = RANGE_BASE_NIB + {2'b00, range_q};
			5'd9: nib_d = device_config_two[7:4];
			5'd10: nib_d = device_config_two[3:0];
			5'd11: nib_d = PRODUCT_REV[7:4];
			5'd12: nib_d = PRODUCT_REV[3:0];
			5'd13: nib_d = device_config_six[3:0];
			5'd14: nib_d = date_year[6:3];
			5'd15: nib_d = {date_year[2:0], date_month[3]};
			5'd16: nib_d = {date_month[2:0], date_day[4]};
			5'd17: nib_d = date_day[3:0];
			5'd18: nib_d = serial_q[7:4];
			5'd19: nib_d = serial_q[3:0];
			5'd20: nib_d = serial_q[15:12];
			5'd21: nib_d = serial_q[11:8];
			5'd22: nib_d = serial_q[23:20];
			5'd23: nib_d = serial_q[19:16];
			5'd24: nib_d = serial_q[31:28];
			5'd25: nib_d = serial_q[27:24];
			// offset and self-test, zero while not enabled or not ready
			5'd26: nib_d = (ext_q && offset_ready) ? raw_offset[3:0] : ZERO_NIB;
			5'd27: nib_d = (ext_q && offset_ready) ? raw_offset[7:4] : ZERO_NIB;
			5'd28: begin
				nib_d[3:2] = (ext_q && selftest_ready) ? averaged_selftest_value[1:0] : 2'b00;
				nib_d[1:0] = (ext_q && offset_ready) ? raw_offset[9:8] : 2'b00;
			end
			5'd29: nib_d = (ext_q && selftest_ready) ? averaged_selftest_value[5:2] : ZERO_NIB;
			5'd30: nib_d = (ext_q && selftest_ready) ? averaged_selftest_value[9:6] : ZERO_NIB;
			5'd31: nib_d = ext_q ? device_config_one[7:4] : ZERO_NIB;
			default: nib_d = ZERO_NIB;
		endcase
	end

	// a repetition count of zero behaves as one
	assign rep_last = ({1'b0, rep_q} + 5'd1) >= {1'b0, rep_k_q};

	// sequencer: one transmission per sync pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			idx_q <= 5'd0;
			rep_q <= 4'd0;
			half_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE, ST_DONE: begin
					if (start_req) begin
						state_q <= ST_SEND;
						idx_q <= 5'd0;
						rep_q <= 4'd0;
						half_q <= 1'b0;
					end
				end
				ST_SEND: begin
					if (sync_evt) begin
						half_q <= !half_q;
						if (half_q) begin
							if (rep_last) begin
								rep_q <= 4'd0;
								idx_q <= idx_q + 5'd1;
								if (idx_q == IDX_LAST) begin
									state_q <= ST_DONE;
								end
							end else begin
								rep_q <= rep_q + 4'd1;
							end
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// transmission outputs; the nibble address wraps after sixteen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_strobe <= 1'b0;
			tx_is_id <= 1'b0;
			tx_nibble <= 4'h0;
			tx_index <= 5'd0;
		end else begin
			tx_strobe <= (state_q == ST_SEND) && sync_evt;
			if ((state_q == ST_SEND) && sync_evt) begin
				tx_is_id <= !half_q;
				tx_nibble <= half_q ? nib_d : idx_q[3:0];
				tx_index <= idx_q;
			end
		end
	end

	// status outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_busy <= 1'b0;
			msg_done <= 1'b0;
		end else begin
			msg_busy <= state_q == ST_SEND;
			msg_done <= state_q == ST_DONE;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic tx_data;
	assign tx_data = tx_strobe && !tx_is_id;

	proto_nibble_a: assert property (tx_data && tx_index == 5'd0 |-> tx_nibble == 4'h4)
		else $error("protocol revision nibble wrong");
	block_count_a: assert property (tx_data && tx_index inside {5'd1, 5'd2}
		|-> tx_nibble == (tx_index == 5'd1 ? 4'h2 : 4'h0))
		else $error("block count nibble wrong");
	sensor_type_a: assert property (tx_data && tx_index inside {5'd5, 5'd6}
		|-> tx_nibble == (tx_index == 5'd6 ? 4'h1 : 4'h0))
		else $error("sensor type nibble wrong");
	axis_code_a: assert property (tx_data && tx_index == 5'd7 |-> tx_nibble[1:0] == 2'b00
		&& tx_nibble[3:2] == $past(axis_q))
		else $error("axis nibble wrong");
	range_code_a: assert property (tx_data && tx_index == 5'd8
		|-> tx_nibble == 4'h7 + {2'b00, $past(range_q)})
		else $error("range nibble wrong");
	date_order_a: assert property (tx_data && tx_index == 5'd17
		|-> tx_nibble == $past(device_config_eight[3:0]))
		else $error("day low nibble wrong");
	offset_low_a: assert property (tx_data && tx_index == 5'd26 && $past(ext_q && offset_ready)
		|-> tx_nibble == $past(raw_offset[3:0]))
		else $error("offset low nibble wrong");
	ext_zero_a: assert property (tx_data && tx_index >= 5'd26 && !$past(ext_q)
		|-> tx_nibble == 4'h0)
		else $error("optional nibble not zero");
	cfg_one_a: assert property (tx_data && tx_index == 5'd31 && $past(ext_q)
		|-> tx_nibble == $past(device_config_one[7:4]))
		else $error("config one nibble wrong");
	self_zero_a: assert property (tx_data && tx_index == 5'd30 && !$past(selftest_ready)
		|-> tx_nibble == 4'h0)
		else $error("unavailable self-test not zero");
	// kind flips on every strobe and a data strobe keeps the index of its id
	id_then_data_a: assert property (tx_strobe |-> tx_is_id != $past(tx_is_id)
		&& (tx_is_id || tx_index == $past(tx_index)))
		else $error("id and data do not alternate");
	maker_hi_a: assert property (tx_data && tx_index == 5'd3
		|-> tx_nibble == $past(maker_code_field[7:4]))
		else $error("maker code nibble wrong");
	serial_hi_a: assert property (tx_data && tx_index == 5'd18
		|-> tx_nibble == $past(serial_q[7:4]))
		else $error("serial nibble wrong");
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");

	full_msg_c: cover property (msg_busy ##1 msg_done);
	ext_msg_c: cover property (tx_data && tx_index == 5'd28 && ext_q);
	bad_addr_c: cover property (pready && pslverr);

endmodule

// ===== tb/sync_source_model.sv
// control unit receiver model that issues sync pulses to the sensor
`timescale 1ns/10ps
module sync_source_model #(
	parameter int PERIOD = 8,
	parameter int HIGH = 3
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control: enable and extra gap for slow periods
	input wire logic run,
	input wire logic [3:0] extra,
	// sync line towards the sensor
	output logic sync_pulse_in
);
	int cnt_q;
	// a started period always finishes, then the line rests low so no stray edge reaches the sensor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			sync_pulse_in <= 1'b0;
		end else if (run || cnt_q != 0) begin
			cnt_q <= (cnt_q >= PERIOD - 1 + int'(extra)) ? 0 : cnt_q + 1;
			sync_pulse_in <= (cnt_q < HIGH);
		end else begin
			sync_pulse_in <= 1'b0;
		end
	end
endmodule

// ===== tb/psi5_init2_data_builder_10bit_bench.sv
// self-checking bench for the phase 2 message builder
`timescale 1ns/10ps
module psi5_init2_data_builder_10bit_bench
	import init2_pkg::*;
;
	localparam logic [7:0] REV = 8'h5a; // value arbitrary
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic offset_ready = 1'b0;
	logic selftest_ready = 1'b0;
	logic [9:0] raw_offset = 10'h000;
	logic [9:0] averaged_selftest_value = 10'h000;
	logic run = 1'b0;
	logic [3:0] extra = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, sync_pulse_in, tx_strobe, tx_is_id, msg_busy, msg_done;
	logic [3:0] tx_nibble;
	logic [4:0] tx_index;
	int fail_count = 0;
	int check_count = 0;
	int seed = 36;
	logic [9:0] exp_q[$];
	logic [7:0] mk, c1, c2, c6, c7, c8;
	logic [31:0] ser;
	logic [31:0] r;
	logic e;

	// free-running clock, 50 ns period
	always #25 pclk = ~pclk;

	init2_message_builder #(.PRODUCT_REV(REV)) i_init2_message_builder (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sync_pulse_in(sync_pulse_in), .offset_ready(offset_ready),
		.raw_offset(raw_offset), .selftest_ready(selftest_ready),
		.averaged_selftest_value(averaged_selftest_value), .tx_strobe(tx_strobe), .tx_is_id(tx_is_id),
		.tx_nibble(tx_nibble), .tx_index(tx_index), .msg_busy(msg_busy), .msg_done(msg_done));
	sync_source_model i_sync_source_model (.pclk(pclk), .presetn(presetn), .run(run), .extra(extra),
		.sync_pulse_in(sync_pulse_in));

	task report_and_stop;
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic bad(input string s);
		fail_count++;
		$display("[FAIL] %0t %s", $time, s);
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50 && pready !== 1'b1) begin
			bad("apb timeout");
			report_and_stop;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
		check_count++;
		if (er !== 1'b0) bad("write refused");
	endtask

	// expected data nibble at index i, gated by availability of the measured values
	function automatic logic [3:0] nib(input int i, input logic [1:0] ax, input logic [1:0] rg,
		input logic ex, input logic eo, input logic es);
		logic [7:0] sb;
		case (i)
			0: nib = PROTO_REV_NIB;
			1: nib = BLOCKS_HI_NIB;
			2: nib = BLOCKS_LO_NIB;
			3: nib = mk[7:4];
			4: nib = mk[3:0];
			5: nib = SENSOR_TYPE_HI_NIB;
			6: nib = SENSOR_TYPE_LO_NIB;
			7: nib = {ax, 2'b00};
			8: nib = RANGE_BASE_NIB + {2'b00, rg};
			9: nib = c2[7:4];
			10: nib = c2[3:0];
			11: nib = REV[7:4];
			12: nib = REV[3:0];
			13: nib = c6[3:0];
			14: nib = c7[6:3];
			15: nib = {c7[2:0], c7[7]};
			16: nib = c8[7:4];
			17: nib = c8[3:0];
			26: nib = eo ? raw_offset[3:0] : ZERO_NIB;
			27: nib = eo ? raw_offset[7:4] : ZERO_NIB;
			28: nib = {es ? averaged_selftest_value[1:0] : 2'b00, eo ? raw_offset[9:8] : 2'b00};
			29: nib = es ? averaged_selftest_value[5:2] : ZERO_NIB;
			30: nib = es ? averaged_selftest_value[9:6] : ZERO_NIB;
			31: nib = ex ? c1[7:4] : ZERO_NIB;
			default: begin
				sb = ser[8 * ((i - 18) / 2) +: 8];
				nib = i[0] ? sb[3:0] : sb[7:4];
			end
		endcase
	endfunction

	// program a message, note every expected transmission, run it to completion
	task automatic run_msg(input logic [1:0] ax, input logic [1:0] rg, input logic ex, input logic [3:0] k,
		input logic ordy, input logic srdy);
		int n;
		int keff;
		logic [31:0] rd;
		logic er;
		{mk, c1, c2, c6} = $random(seed);
		{c7, c8} = 16'($random(seed));
		ser = $random(seed);
		raw_offset <= 10'($random(seed));
		averaged_selftest_value <= 10'($random(seed));
		offset_ready <= ordy;
		selftest_ready <= srdy;
		extra <= 4'($random(seed)) & 4'h7;
		wr(MAKER_OFS, {24'h0, mk});
		wr(CFG_ONE_OFS, {24'h0, c1});
		wr(CFG_TWO_OFS, {24'h0, c2});
		wr(CFG_SIX_OFS, {24'h0, c6});
		wr(CFG_SEVEN_OFS, {24'h0, c7});
		wr(CFG_EIGHT_OFS, {24'h0, c8});
		wr(SERIAL_OFS, ser);
		keff = (k == 4'h0) ? 1 : int'(k);
		for (int i = 0; i < NIB_COUNT; i++) begin
			for (int j = 0; j < keff; j++) begin
				exp_q.push_back({1'b1, 4'(i), 5'(i)});
				exp_q.push_back({1'b0, nib(i, ax, rg, ex, ex & ordy, ex & srdy), 5'(i)});
			end
		end
		wr(CTRL_OFS, {20'h0, rg, ax, k, 2'b00, ex, 1'b1});
		run <= 1'b1;
		repeat (3) @(posedge pclk);
		check_count++;
		if (msg_busy !== 1'b1) bad("not busy after start");
		n = 0;
		while (msg_done !== 1'b1 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		run <= 1'b0;
		check_count++;
		if (n >= 20000 || exp_q.size() != 0) bad("message incomplete");
		// a hung message ends the run at once
		if (n >= 20000) report_and_stop;
		apb(1'b0, STATUS_OFS, 32'h0, rd, er);
		check_count++;
		if (rd[ST_DONE_BIT] !== 1'b1 || rd[ST_BUSY_BIT] !== 1'b0 || er !== 1'b0) bad("status wrong");
	endtask

	// compare each transmission with the oldest note
	always @(posedge pclk) begin
		if (tx_strobe === 1'b1) begin
			check_count++;
			if (exp_q.size() == 0 || {tx_is_id, tx_nibble, tx_index} !== exp_q[0]) begin
				bad("unexpected transmission");
			end
			if (exp_q.size() != 0) void'(exp_q.pop_front());
		end
	end

	// main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CTRL_OFS, 32'h0, r, e);
		check_count++;
		if (r !== {24'h0, REP_RESET, 4'h0} || e !== 1'b0) bad("control reset value");
		// unmapped place refuses both directions, reads zero
		for (int w = 0; w < 2; w++) begin
			apb(w[0], 8'h40, 32'hffff_ffff, r, e);
			check_count++;
			if (e !== 1'b1 || (w == 0 && r !== 32'h0)) bad("unmapped access");
		end
		run_msg(2'b00, 2'b00, 1'b1, 4'h1, 1'b1, 1'b1);
		run_msg(2'b01, 2'b01, 1'b0, 4'h2, 1'b1, 1'b1);
		run_msg(2'b10, 2'b10, 1'b1, 4'h0, 1'b0, 1'b1);
		run_msg(2'b11, 2'b11, 1'b1, 4'h3, 1'b1, 1'b0);
		report_and_stop;
	end
endmodule
